// file: dba_pkg.sv
package dba_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 2;
  localparam int NUM_SRC = 4;
  localparam int ADDR_W = 26;
  localparam int CNT_W = 16;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // arbiter source index, higher index wins
  // ----------------------------------------------------------------
  localparam int SRC_CH0 = 0;
  localparam int SRC_CH1 = 1;
  localparam int SRC_EXT = 2;
  localparam int SRC_REF = 3;

  // ----------------------------------------------------------------
  // reset values and unit sizes
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 26'h0000000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [NUM_SRC-1:0] GNT_RST = 4'h0;
  localparam logic [1:0] UNIT_BYTE = 2'h1;
  localparam logic [1:0] UNIT_WORD = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_SINGLE, MODE_BLOCK, MODE_DEMAND} dba_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dba_state_t;

endpackage

// file: dba_chan.sv
`timescale 1ns/10ps
module dba_chan (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_load,
  input wire logic cfg_compat,
  input wire dba_pkg::dba_mode_t cfg_mode,
  input wire logic cfg_dir,
  input wire logic [dba_pkg::ADDR_W-1:0] cfg_req_addr,
  input wire logic cfg_req_io,
  input wire logic cfg_req_wide,
  input wire logic [dba_pkg::ADDR_W-1:0] cfg_tgt_addr,
  input wire logic cfg_tgt_io,
  input wire logic cfg_tgt_wide,
  input wire logic [dba_pkg::CNT_W-1:0] cfg_count,
  input wire logic dreq,
  input wire logic end_req,
  input wire logic step,
  input wire logic [1:0] step_bytes,
  output logic want,
  output logic [dba_pkg::ADDR_W-1:0] src_addr,
  output logic src_io,
  output logic src_wide,
  output logic [dba_pkg::ADDR_W-1:0] dst_addr,
  output logic dst_io,
  output logic dst_wide,
  output logic [dba_pkg::CNT_W-1:0] count,
  output dba_pkg::dba_mode_t mode,
  output logic en,
  output logic done
);
  import dba_pkg::*;

  logic act, hold;
  logic next_act, next_hold, next_en, next_done;
  logic next_src_io, next_src_wide, next_dst_io, next_dst_wide;
  logic [ADDR_W-1:0] next_src_addr, next_dst_addr;
  logic [CNT_W-1:0] next_count;
  dba_mode_t next_mode;

  // ----------------------------------------------------------------
  // channel state
  // ----------------------------------------------------------------
  always_comb begin
    next_act = act;
    next_hold = hold;
    next_en = en;
    next_done = done;
    next_src_addr = src_addr;
    next_src_io = src_io;
    next_src_wide = src_wide;
    next_dst_addr = dst_addr;
    next_dst_io = dst_io;
    next_dst_wide = dst_wide;
    next_count = count;
    next_mode = mode;
    if (cfg_load && !en) begin
      next_src_addr = cfg_dir ? cfg_req_addr : cfg_tgt_addr;
      next_src_io = cfg_dir ? cfg_req_io : cfg_tgt_io;
      next_src_wide = !cfg_compat && (cfg_dir ? cfg_req_wide : cfg_tgt_wide);
      next_dst_addr = cfg_dir ? cfg_tgt_addr : cfg_req_addr;
      next_dst_io = cfg_dir ? cfg_tgt_io : cfg_req_io;
      next_dst_wide = !cfg_compat && (cfg_dir ? cfg_tgt_wide : cfg_req_wide);
      next_count = cfg_count;
      next_mode = cfg_compat ? MODE_SINGLE : cfg_mode;
      next_en = cfg_count != CNT_RST;
      next_done = 1'b0;
      next_act = 1'b0;
      next_hold = 1'b0;
    end else if (en) begin
      if (end_req) begin
        next_en = 1'b0;
        next_act = 1'b0;
        next_done = 1'b1;
      end else begin
        if (mode == MODE_BLOCK && dreq) begin
          next_act = 1'b1;
        end
        if (!dreq) begin
          next_hold = 1'b0;
        end
        if (step) begin
          next_count = count - CNT_W'(step_bytes);
          if (!src_io) begin
            next_src_addr = src_addr + ADDR_W'(step_bytes);
          end
          if (!dst_io) begin
            next_dst_addr = dst_addr + ADDR_W'(step_bytes);
          end
          if (mode == MODE_SINGLE) begin
            next_hold = 1'b1;
          end
          if (count == CNT_W'(step_bytes)) begin
            next_en = 1'b0;
            next_act = 1'b0;
            next_done = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act <= 1'b0;
      hold <= 1'b0;
      en <= 1'b0;
      done <= 1'b0;
      src_addr <= ADDR_RST;
      src_io <= 1'b0;
      src_wide <= 1'b0;
      dst_addr <= ADDR_RST;
      dst_io <= 1'b0;
      dst_wide <= 1'b0;
      count <= CNT_RST;
      mode <= MODE_SINGLE;
    end else begin
      act <= next_act;
      hold <= next_hold;
      en <= next_en;
      done <= next_done;
      src_addr <= next_src_addr;
      src_io <= next_src_io;
      src_wide <= next_src_wide;
      dst_addr <= next_dst_addr;
      dst_io <= next_dst_io;
      dst_wide <= next_dst_wide;
      count <= next_count;
      mode <= next_mode;
    end
  end

  // bus wanted on requester demand; block mode keeps it wanted from the first demand until the channel ends
  always_comb begin
    case (mode)
      MODE_BLOCK: want = en && act;
      MODE_DEMAND: want = en && dreq;
      default: want = en && dreq && !hold;
    endcase
  end

endmodule

// file: dba_arb.sv
`timescale 1ns/10ps
module dba_arb (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dba_pkg::NUM_SRC-1:0] req,
  input wire logic core_hlda,
  input wire logic powerdown,
  input wire logic swap_ok,
  output logic core_hold,
  output logic [dba_pkg::NUM_SRC-1:0] gnt
);
  import dba_pkg::*;

  logic [NUM_SRC-1:0] live, pick, next_gnt;

  // ----------------------------------------------------------------
  // priority pick and grant lock
  // ----------------------------------------------------------------
  always_comb begin
    live = powerdown ? GNT_RST : req;
    core_hold = |live;
    pick = GNT_RST;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (live[i]) begin
        pick = GNT_RST;
        pick[i] = 1'b1;
      end
    end
    if (!core_hlda) begin
      next_gnt = GNT_RST;
    end else if (|(gnt & live) && !(|gnt[SRC_CH1:SRC_CH0] && swap_ok)) begin
      next_gnt = gnt;
    end else begin
      next_gnt = pick;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gnt <= GNT_RST;
    end else begin
      gnt <= next_gnt;
    end
  end

endmodule

// file: dba_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - the two channels keep separate state and one never changes the other.
// - each channel runs single, block or demand mode, and a compat flag forces byte-wide single.
// - source and destination are each memory or i/o and each 8 or 16 bits wide.
// - a temporary register packs byte reads into word writes and splits word reads into bytes.
// - the arbiter takes requests from both channels, an external master and refresh.
// - any live request raises the hold to the core, and after its grant priority picks one.
// - each channel is loaded with a requester, a target and a byte count.
// - only the requester's request and end lines start, drive or stop a channel.
// - the target has no line into the block and only answers bus cycles.
// - the amount moved equals the byte count loaded, or is less if the requester's end line stops the channel first.
// - in powerdown no channel, refresh or external hold request is honoured.
module dba_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic powerdown,
  input wire logic core_hlda,
  output logic core_hold,
  input wire logic [dba_pkg::NUM_CH-1:0] cfg_load,
  input wire logic [dba_pkg::NUM_CH-1:0] cfg_compat,
  input wire dba_pkg::dba_mode_t cfg_mode [dba_pkg::NUM_CH],
  input wire logic [dba_pkg::NUM_CH-1:0] cfg_dir,
  input wire logic [dba_pkg::NUM_CH-1:0][dba_pkg::ADDR_W-1:0] cfg_req_addr,
  input wire logic [dba_pkg::NUM_CH-1:0] cfg_req_io,
  input wire logic [dba_pkg::NUM_CH-1:0] cfg_req_wide,
  input wire logic [dba_pkg::NUM_CH-1:0][dba_pkg::ADDR_W-1:0] cfg_tgt_addr,
  input wire logic [dba_pkg::NUM_CH-1:0] cfg_tgt_io,
  input wire logic [dba_pkg::NUM_CH-1:0] cfg_tgt_wide,
  input wire logic [dba_pkg::NUM_CH-1:0][dba_pkg::CNT_W-1:0] cfg_count,
  input wire logic [dba_pkg::NUM_CH-1:0] dreq_pin,
  input wire logic [dba_pkg::NUM_CH-1:0] term_n_pin,
  output logic [dba_pkg::NUM_CH-1:0] chan_done,
  input wire logic ext_hold_pin,
  output logic ext_hlda,
  input wire logic ref_req,
  output logic ref_ack,
  output logic bus_cyc,
  output logic bus_we,
  output logic bus_io,
  output logic bus_word,
  output logic [dba_pkg::ADDR_W-1:0] bus_addr,
  output logic [dba_pkg::DATA_W-1:0] bus_wdata,
  input wire logic [dba_pkg::DATA_W-1:0] bus_rdata,
  input wire logic bus_ready
);
  import dba_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] dreq_s1, dreq_s2, term_s1, term_s2;
  logic ext_s1, ext_s2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dreq_s1 <= 2'h0;
      dreq_s2 <= 2'h0;
      term_s1 <= 2'h3;
      term_s2 <= 2'h3;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else begin
      dreq_s1 <= dreq_pin;
      dreq_s2 <= dreq_s1;
      term_s1 <= term_n_pin;
      term_s2 <= term_s1;
      ext_s1 <= ext_hold_pin;
      ext_s2 <= ext_s1;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] ch_want, ch_en, ch_step, ch_src_io, ch_src_wide, ch_dst_io, ch_dst_wide;
  logic [NUM_CH-1:0][ADDR_W-1:0] ch_src_addr, ch_dst_addr;
  logic [NUM_CH-1:0][CNT_W-1:0] ch_count;
  dba_mode_t ch_mode [NUM_CH];
  logic step_r, owner;
  logic [1:0] step_bytes;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign ch_step[c] = step_r && (owner == 1'(c));
    dba_chan u_chan (
      .clk(clk),
      .rst_n(rst_n),
      .cfg_load(cfg_load[c]),
      .cfg_compat(cfg_compat[c]),
      .cfg_mode(cfg_mode[c]),
      .cfg_dir(cfg_dir[c]),
      .cfg_req_addr(cfg_req_addr[c]),
      .cfg_req_io(cfg_req_io[c]),
      .cfg_req_wide(cfg_req_wide[c]),
      .cfg_tgt_addr(cfg_tgt_addr[c]),
      .cfg_tgt_io(cfg_tgt_io[c]),
      .cfg_tgt_wide(cfg_tgt_wide[c]),
      .cfg_count(cfg_count[c]),
      .dreq(dreq_s2[c]),
      .end_req(!term_s2[c]),
      .step(ch_step[c]),
      .step_bytes(step_bytes),
      .want(ch_want[c]),
      .src_addr(ch_src_addr[c]),
      .src_io(ch_src_io[c]),
      .src_wide(ch_src_wide[c]),
      .dst_addr(ch_dst_addr[c]),
      .dst_io(ch_dst_io[c]),
      .dst_wide(ch_dst_wide[c]),
      .count(ch_count[c]),
      .mode(ch_mode[c]),
      .en(ch_en[c]),
      .done(chan_done[c])
    );
  end

  // ----------------------------------------------------------------
  // arbiter
  // ----------------------------------------------------------------
  dba_state_t state, next_state;
  logic [NUM_SRC-1:0] arb_req, gnt;
  logic busy, start, csel;

  assign busy = (state != ST_IDLE) || step_r;
  assign csel = gnt[SRC_CH1];
  assign start = (state == ST_IDLE) && !step_r && |(gnt[SRC_CH1:SRC_CH0] & ch_want);

  always_comb begin
    arb_req[SRC_CH0] = ch_want[0] || (busy && !owner);
    arb_req[SRC_CH1] = ch_want[1] || (busy && owner);
    arb_req[SRC_EXT] = ext_s2;
    arb_req[SRC_REF] = ref_req;
  end

  dba_arb u_arb (
    .clk(clk),
    .rst_n(rst_n),
    .req(arb_req),
    .core_hlda(core_hlda),
    .powerdown(powerdown),
    .swap_ok(!busy && !start),
    .core_hold(core_hold),
    .gnt(gnt)
  );

  assign ext_hlda = gnt[SRC_EXT];
  assign ref_ack = gnt[SRC_REF];

  // ----------------------------------------------------------------
  // transfer engine with packing register
  // ----------------------------------------------------------------
  logic [1:0] unit, next_unit, unit_new;
  logic idx, next_idx, next_owner, next_step, last_rd, last_wr;
  logic next_cyc, next_we, next_io, next_word;
  logic [ADDR_W-1:0] next_addr, s_addr, d_addr;
  logic [DATA_W-1:0] temp, next_temp, next_wdata, rd_temp;
  logic [1:0] next_step_bytes;
  logic s_io, s_wide, d_io, d_wide;
  logic [7:0] rd_byte;

  always_comb begin
    s_addr = ch_src_addr[owner];
    s_io = ch_src_io[owner];
    s_wide = ch_src_wide[owner];
    d_addr = ch_dst_addr[owner];
    d_io = ch_dst_io[owner];
    d_wide = ch_dst_wide[owner];
    unit_new = UNIT_BYTE;
    if (ch_count[csel] > 16'h0001
        && ((ch_src_wide[csel] && !ch_src_addr[csel][0])
        || (ch_dst_wide[csel] && !ch_dst_addr[csel][0]))) begin
      unit_new = UNIT_WORD;
    end
    rd_byte = bus_addr[0] ? bus_rdata[15:8] : bus_rdata[7:0];
    rd_temp = temp;
    if (bus_word) begin
      rd_temp = bus_rdata;
    end else if (idx) begin
      rd_temp[15:8] = rd_byte;
    end else begin
      rd_temp[7:0] = rd_byte;
    end
    last_rd = bus_word || unit != UNIT_WORD || idx;
    last_wr = bus_word || unit != UNIT_WORD || idx;
    next_state = state;
    next_owner = owner;
    next_unit = unit;
    next_idx = idx;
    next_temp = temp;
    next_cyc = bus_cyc;
    next_we = bus_we;
    next_io = bus_io;
    next_word = bus_word;
    next_addr = bus_addr;
    next_wdata = bus_wdata;
    next_step = 1'b0;
    next_step_bytes = step_bytes;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_owner = csel;
          next_unit = unit_new;
          next_idx = 1'b0;
          next_state = ST_READ;
          next_cyc = 1'b1;
          next_we = 1'b0;
          next_io = ch_src_io[csel];
          next_word = ch_src_wide[csel] && !ch_src_addr[csel][0] && unit_new == UNIT_WORD;
          next_addr = ch_src_addr[csel];
        end
      end
      ST_READ: begin
        if (bus_ready) begin
          next_temp = rd_temp;
          if (last_rd) begin
            next_state = ST_WRITE;
            next_idx = 1'b0;
            next_we = 1'b1;
            next_io = d_io;
            next_word = d_wide && !d_addr[0] && unit == UNIT_WORD;
            next_addr = d_addr;
            next_wdata = next_word ? rd_temp : {rd_temp[7:0], rd_temp[7:0]};
          end else begin
            next_idx = 1'b1;
            next_addr = s_io ? s_addr : s_addr + 26'h0000001;
          end
        end
      end
      ST_WRITE: begin
        if (bus_ready) begin
          if (last_wr) begin
            next_state = ST_IDLE;
            next_cyc = 1'b0;
            next_we = 1'b0;
            next_step = 1'b1;
            next_step_bytes = unit;
          end else begin
            next_idx = 1'b1;
            next_addr = d_io ? d_addr : d_addr + 26'h0000001;
            next_wdata = {temp[15:8], temp[15:8]};
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cyc = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      owner <= 1'b0;
      unit <= UNIT_BYTE;
      idx <= 1'b0;
      temp <= DATA_RST;
      bus_cyc <= 1'b0;
      bus_we <= 1'b0;
      bus_io <= 1'b0;
      bus_word <= 1'b0;
      bus_addr <= ADDR_RST;
      bus_wdata <= DATA_RST;
      step_r <= 1'b0;
      step_bytes <= UNIT_BYTE;
    end else begin
      state <= next_state;
      owner <= next_owner;
      unit <= next_unit;
      idx <= next_idx;
      temp <= next_temp;
      bus_cyc <= next_cyc;
      bus_we <= next_we;
      bus_io <= next_io;
      bus_word <= next_word;
      bus_addr <= next_addr;
      bus_wdata <= next_wdata;
      step_r <= next_step;
      step_bytes <= next_step_bytes;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_chan_indep: assert property ((ch_step[0] && !cfg_load[1]) |=> $stable(ch_count[1]))
    else $error("channel 1 count moved on a channel 0 step");
  a_compat_mode: assert property ((cfg_load[1] && cfg_compat[1] && !ch_en[1])
    |=> ch_mode[1] == MODE_SINGLE && !ch_src_wide[1] && !ch_dst_wide[1])
    else $error("compat load did not force byte single mode");
  a_word_align: assert property ((bus_cyc && bus_word) |-> !bus_addr[0])
    else $error("word cycle on an odd address");
  a_pack_split: assert property ((state == ST_READ && bus_ready && bus_word && !d_wide)
    |=> state == ST_WRITE && !bus_word && bus_wdata[7:0] == $past(bus_rdata[7:0]))
    else $error("word read not split into a low byte write");
  a_ref_served: assert property ((ref_req && core_hlda && !powerdown && !busy)
    |=> ref_ack || $past(|gnt[SRC_EXT:SRC_CH0]))
    else $error("refresh request not granted");
  a_hold_raise: assert property ((|arb_req && !powerdown) |-> core_hold)
    else $error("live request without hold to core");
  a_grant_hlda: assert property (|gnt |-> $past(core_hlda) && $onehot(gnt))
    else $error("grant without core hold acknowledge");
  a_cfg_loaded: assert property ((cfg_load[0] && !ch_en[0]) |=> ch_count[0] == $past(cfg_count[0]))
    else $error("byte count not loaded");
  a_end_stops: assert property ((!term_s2[0] && ch_en[0]) |=> !ch_en[0] && !ch_want[0] && chan_done[0])
    else $error("requester end did not stop the channel");
  a_count_step: assert property ((ch_step[0] && ch_en[0])
    |=> ch_count[0] == $past(ch_count[0]) - 16'($past(step_bytes)))
    else $error("count not reduced by the bytes moved");
  a_count_zero: assert property ((ch_step[0] && ch_en[0] && ch_count[0] == 16'(step_bytes))
    |=> !ch_en[0] && chan_done[0] ##1 !arb_req[SRC_CH0])
    else $error("channel kept its request after count exhausted");
  a_pd_quiet: assert property (powerdown |-> !core_hold)
    else $error("request honoured in powerdown");

  c_both_ch: cover property (ch_step[0] ##[1:50] ch_step[1]);
  c_pack_word: cover property (state == ST_READ && !bus_word ##[1:8] state == ST_WRITE && bus_word);
  c_ext_grant: cover property (ext_hlda);
  c_term_end: cover property (!term_s2[1] && ch_en[1]);

endmodule

// file: dba_mem_model.sv
`timescale 1ns/10ps
module dba_mem_model (
  input wire logic clk,
  input wire logic bus_cyc,
  input wire logic bus_we,
  input wire logic bus_word,
  input wire logic [dba_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [dba_pkg::DATA_W-1:0] bus_wdata,
  input wire logic [3:0] wait_n,
  output logic [dba_pkg::DATA_W-1:0] bus_rdata,
  output logic bus_ready
);
  import dba_pkg::*;
  // ----------------------------------------------------------------
  // passive memory and i/o slave
  // ----------------------------------------------------------------
  logic [15:0] mem [64];
  logic [3:0] cnt;
  logic [5:0] idx;
  assign idx = bus_addr[6:1];
  initial begin
    cnt = 4'h0;
    bus_ready = 1'b0;
    bus_rdata = 16'h0000;
  end
  // answers only bus cycles, after wait_n wait cycles; idle data keeps moving
  always @(negedge clk) begin
    if (bus_cyc && cnt == wait_n) begin
      cnt <= 4'h0;
      bus_ready <= 1'b1;
      bus_rdata <= mem[idx];
    end else begin
      bus_ready <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_cyc) cnt <= cnt + 4'h1;
    end
  end
  always @(posedge clk) begin
    if (bus_cyc && bus_ready) begin
      if (bus_we && bus_word) mem[idx] <= bus_wdata;
      else if (bus_we && bus_addr[0]) mem[idx][15:8] <= bus_wdata[15:8];
      else if (bus_we) mem[idx][7:0] <= bus_wdata[7:0];
    end
  end
endmodule

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dba_pkg::*;
  logic clk, rst_n, powerdown, core_hlda, core_hold;
  logic ext_hold_pin, ext_hlda, ref_req, ref_ack;
  logic [NUM_CH-1:0] cfg_load, cfg_compat, cfg_dir, cfg_req_io, cfg_req_wide;
  logic [NUM_CH-1:0] cfg_tgt_io, cfg_tgt_wide, dreq_pin, term_n_pin, chan_done;
  dba_mode_t cfg_mode [NUM_CH];
  logic [NUM_CH-1:0][ADDR_W-1:0] cfg_req_addr, cfg_tgt_addr;
  logic [NUM_CH-1:0][CNT_W-1:0] cfg_count;
  logic bus_cyc, bus_we, bus_io, bus_word, bus_ready;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata;
  logic [3:0] wait_n;
  logic io_seen;
  int fail_count, samples_checked, cycles;

  dba_top i_dut (.clk(clk), .rst_n(rst_n), .powerdown(powerdown), .core_hlda(core_hlda),
    .core_hold(core_hold), .cfg_load(cfg_load), .cfg_compat(cfg_compat), .cfg_mode(cfg_mode),
    .cfg_dir(cfg_dir), .cfg_req_addr(cfg_req_addr), .cfg_req_io(cfg_req_io),
    .cfg_req_wide(cfg_req_wide), .cfg_tgt_addr(cfg_tgt_addr), .cfg_tgt_io(cfg_tgt_io),
    .cfg_tgt_wide(cfg_tgt_wide), .cfg_count(cfg_count), .dreq_pin(dreq_pin),
    .term_n_pin(term_n_pin), .chan_done(chan_done), .ext_hold_pin(ext_hold_pin),
    .ext_hlda(ext_hlda), .ref_req(ref_req), .ref_ack(ref_ack), .bus_cyc(bus_cyc),
    .bus_we(bus_we), .bus_io(bus_io), .bus_word(bus_word), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ready(bus_ready));
  dba_mem_model i_mem (.clk(clk), .bus_cyc(bus_cyc), .bus_we(bus_we), .bus_word(bus_word),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .wait_n(wait_n), .bus_rdata(bus_rdata),
    .bus_ready(bus_ready));

  // ----------------------------------------------------------------
  // clock, core grant follower, timeout
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(negedge clk) core_hlda <= core_hold;
  always @(posedge clk) begin
    if (bus_cyc && bus_ready && bus_io) io_seen <= 1'b1;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      $display("[FAIL] timeout expected finish seen hang");
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0b seen %0b", what, exp, got);
    end
  endtask
  task automatic chk_word(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // rf and tf are {io, wide}
  task automatic load(int c, dba_mode_t m, logic cp, logic d, logic [ADDR_W-1:0] ra,
      logic [1:0] rf, logic [ADDR_W-1:0] ta, logic [1:0] tf, logic [CNT_W-1:0] n);
    @(negedge clk);
    cfg_mode[c] = m;
    cfg_compat[c] = cp;
    cfg_dir[c] = d;
    cfg_req_addr[c] = ra;
    {cfg_req_io[c], cfg_req_wide[c]} = rf;
    cfg_tgt_addr[c] = ta;
    {cfg_tgt_io[c], cfg_tgt_wide[c]} = tf;
    cfg_count[c] = n;
    cfg_load[c] = 1'b1;
    @(negedge clk);
    cfg_load[c] = 1'b0;
  endtask
  task automatic pulse(int c, int n);
    dreq_pin[c] = 1'b1;
    repeat (n) @(negedge clk);
    dreq_pin[c] = 1'b0;
  endtask
  task automatic wait_done(int c, int lim);
    int i;
    i = 0;
    while (chan_done[c] !== 1'b1 && i < lim) begin
      @(negedge clk);
      i++;
    end
    chk_bit("chan_done", 1'b1, chan_done[c]);
  endtask
  task automatic test_done();
    $display("TB: checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_pack();
    wait_n = 4'h0;
    i_mem.mem[16] = 16'h2211;
    i_mem.mem[17] = 16'h4433;
    i_mem.mem[32] = 16'h0000;
    i_mem.mem[33] = 16'h0000;
    load(0, MODE_BLOCK, 1'b0, 1'b1, 26'h20, 2'h0, 26'h40, 2'h1, 16'h0004);
    pulse(0, 4);
    wait_done(0, 200);
    chk_word("dst word0", 16'h2211, i_mem.mem[32]);
    chk_word("dst word1", 16'h4433, i_mem.mem[33]);
    repeat (4) @(negedge clk);
    chk_bit("core_hold", 1'b0, core_hold);
    $display("test pack done");
  endtask
  task automatic test_split();
    wait_n = 4'h2;
    i_mem.mem[24] = 16'h6655;
    i_mem.mem[25] = 16'h8877;
    i_mem.mem[40] = 16'h0000;
    i_mem.mem[41] = 16'heedd;
    load(1, MODE_DEMAND, 1'b0, 1'b1, 26'h30, 2'h1, 26'h50, 2'h0, 16'h0003);
    dreq_pin[1] = 1'b1;
    wait_done(1, 400);
    dreq_pin[1] = 1'b0;
    chk_word("split word", 16'h6655, i_mem.mem[40]);
    chk_word("odd byte", 16'hee77, i_mem.mem[41]);
    $display("test split done");
  endtask
  task automatic test_term();
    wait_n = 4'h6;
    i_mem.mem[63] = 16'h5a5a;
    load(0, MODE_BLOCK, 1'b0, 1'b1, 26'h00, 2'h0, 26'h70, 2'h0, 16'h0010);
    pulse(0, 4);
    repeat (40) @(negedge clk);
    term_n_pin[0] = 1'b0;
    repeat (4) @(negedge clk);
    term_n_pin[0] = 1'b1;
    wait_done(0, 60);
    repeat (40) @(negedge clk);
    chk_bit("bus_cyc", 1'b0, bus_cyc);
    chk_word("tail untouched", 16'h5a5a, i_mem.mem[63]);
    $display("test term done");
  endtask
  task automatic test_both();
    chk_bit("bus_io early", 1'b0, io_seen);
    wait_n = 4'h1;
    i_mem.mem[48] = 16'hc3c2;
    i_mem.mem[56] = 16'h0000;
    i_mem.mem[50] = 16'hbbaa;
    i_mem.mem[5] = 16'h0000;
    load(0, MODE_BLOCK, 1'b0, 1'b1, 26'h60, 2'h1, 26'h70, 2'h1, 16'h0002);
    load(1, MODE_BLOCK, 1'b0, 1'b0, 26'h0a, 2'h2, 26'h64, 2'h1, 16'h0002);
    dreq_pin = 2'h3;
    repeat (4) @(negedge clk);
    dreq_pin = 2'h0;
    wait_done(0, 300);
    wait_done(1, 300);
    chk_word("ch0 word", 16'hc3c2, i_mem.mem[56]);
    chk_word("ch1 io port", 16'h00bb, i_mem.mem[5]);
    chk_bit("bus_io port", 1'b1, io_seen);
    $display("test both done");
  endtask
  task automatic test_single();
    wait_n = 4'h0;
    i_mem.mem[4] = 16'h9988;
    i_mem.mem[6] = 16'h0000;
    load(1, MODE_BLOCK, 1'b1, 1'b1, 26'h08, 2'h1, 26'h0c, 2'h1, 16'h0002);
    pulse(1, 3);
    repeat (30) @(negedge clk);
    chk_bit("chan_done", 1'b0, chan_done[1]);
    chk_word("one byte", 16'h0088, i_mem.mem[6]);
    pulse(1, 3);
    wait_done(1, 100);
    chk_word("two bytes", 16'h9988, i_mem.mem[6]);
    $display("test single done");
  endtask
  task automatic test_arb();
    powerdown = 1'b1;
    ref_req = 1'b1;
    ext_hold_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk_bit("core_hold", 1'b0, core_hold);
    chk_bit("ref_ack", 1'b0, ref_ack);
    chk_bit("ext_hlda", 1'b0, ext_hlda);
    powerdown = 1'b0;
    repeat (8) @(negedge clk);
    chk_bit("core_hold", 1'b1, core_hold);
    chk_bit("ref_ack", 1'b1, ref_ack);
    chk_bit("ext_hlda", 1'b0, ext_hlda);
    ref_req = 1'b0;
    repeat (8) @(negedge clk);
    chk_bit("ref_ack", 1'b0, ref_ack);
    chk_bit("ext_hlda", 1'b1, ext_hlda);
    ext_hold_pin = 1'b0;
    repeat (8) @(negedge clk);
    chk_bit("ext_hlda", 1'b0, ext_hlda);
    chk_bit("core_hold", 1'b0, core_hold);
    $display("test arb done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {fail_count, samples_checked, cycles} = '0;
    {rst_n, powerdown, core_hlda, ext_hold_pin, ref_req} = '0;
    {cfg_load, cfg_compat, cfg_dir, cfg_req_io, cfg_req_wide} = '0;
    {cfg_tgt_io, cfg_tgt_wide, dreq_pin} = '0;
    term_n_pin = 2'h3;
    cfg_mode[0] = MODE_SINGLE;
    cfg_mode[1] = MODE_SINGLE;
    cfg_req_addr = '0;
    cfg_tgt_addr = '0;
    cfg_count = '0;
    wait_n = 4'h0;
    io_seen = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit("chan_done0", 1'b0, chan_done[0]);
    chk_bit("bus_cyc", 1'b0, bus_cyc);
    test_pack();
    test_split();
    test_term();
    test_both();
    test_single();
    test_arb();
    test_done();
  end
endmodule
